//--- dopfs_defs.svh
`ifndef DOPFS_DEFS_SVH
`define DOPFS_DEFS_SVH

// ----------------------------------------
// time base
// ----------------------------------------
`define DOPFS_CLK_PERIOD_NS 40
`define DOPFS_TICK_NS 100000
`define DOPFS_TICK_CYC (`DOPFS_TICK_NS / `DOPFS_CLK_PERIOD_NS)
`define DOPFS_LOCATE_MS 10000
`define DOPFS_LOCATE_TICKS (`DOPFS_LOCATE_MS * 10)

// ----------------------------------------
// register offsets
// ----------------------------------------
`define DOPFS_A_DOVAL 8'h00
`define DOPFS_A_PCMD 8'h04
`define DOPFS_A_FS_STAGE 8'h08
`define DOPFS_A_FS_APPLY 8'h0c
`define DOPFS_A_WDT_CTRL 8'h10
`define DOPFS_A_HOST_IDLE 8'h14
`define DOPFS_A_PEER_IDLE 8'h18
`define DOPFS_A_LOCATE 8'h1c
`define DOPFS_A_STATUS 8'h20
`define DOPFS_A_IRQ_STAT 8'h24
`define DOPFS_A_IRQ_EN 8'h28
`define DOPFS_A_IRQ_CLR 8'h2c
`define DOPFS_A_CH_BASE 8'h40
`define DOPFS_CH_STRIDE 16
`define DOPFS_CH_CFG 4'h0
`define DOPFS_CH_WIDTH 4'h4
`define DOPFS_CH_COUNT 4'h8
`define DOPFS_CH_DELAY 4'hc

// ----------------------------------------
// field positions
// ----------------------------------------
`define DOPFS_STOP_LSB 16
`define DOPFS_CFG_CONT_BIT 2
`define DOPFS_WIDTH_HI_LSB 16
`define DOPFS_ST_BUSY_LSB 8
`define DOPFS_ST_HOST_EXP 16
`define DOPFS_ST_PEER_EXP 17
`define DOPFS_ST_FAILSAFE 18
`define DOPFS_ST_LED 19
`define DOPFS_IRQ_HOST 16
`define DOPFS_IRQ_PEER 17
`define DOPFS_IRQ_W 18

`endif

//--- dopfs_pkg.sv
`default_nettype none
package dopfs_pkg;
    typedef enum logic [3:0]
    {
        DOPFS_DIRECT = 4'b0001,
        DOPFS_PULSE = 4'b0010,
        DOPFS_L2H = 4'b0100,
        DOPFS_H2L = 4'b1000
    } dopfs_mode_t;
endpackage
`default_nettype wire

//--- dopfs_top.sv
`include "dopfs_defs.svh"
`default_nettype none
module dopfs_top
    import dopfs_pkg::*;
#(
    parameter int NCH = 4,
    parameter int IDLE_W = 24,
    parameter int TICK_CYC = `DOPFS_TICK_CYC,
    parameter int LOCATE_TICKS = `DOPFS_LOCATE_TICKS
)
(
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    input wire logic ce_i,
    input wire logic [7:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    input wire logic host_pkt_i,
    input wire logic peer_pkt_i,
    output logic [NCH-1:0] do_o,
    output logic led_o,
    output logic irq_o
);

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic dopfs_mode_t mode_dec(input logic [1:0] code);
        dopfs_mode_t m;
        m = DOPFS_DIRECT;
        unique case (code)
            2'h0: m = DOPFS_DIRECT;
            2'h1: m = DOPFS_PULSE;
            2'h2: m = DOPFS_L2H;
            2'h3: m = DOPFS_H2L;
        endcase
        return m;
    endfunction

    function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
        return a == b;
    endfunction

    // ----------------------------------------
    // global registers
    // ----------------------------------------
    localparam int TW = $clog2(TICK_CYC + 1);
    localparam int LW = $clog2(LOCATE_TICKS + 1);
    logic [TW-1:0] tick_cnt_reg;
    logic tick;
    logic [NCH-1:0] doval_reg;
    logic [NCH-1:0] fs_stage_reg;
    logic [NCH-1:0] fs_applied_reg;
    logic host_en_reg;
    logic peer_en_reg;
    logic [IDLE_W-1:0] host_idle_reg;
    logic [IDLE_W-1:0] peer_idle_reg;
    logic [IDLE_W-1:0] host_cnt_reg;
    logic [IDLE_W-1:0] peer_cnt_reg;
    logic host_exp_reg;
    logic peer_exp_reg;
    logic host_ev;
    logic peer_ev;
    logic failsafe;
    logic [LW-1:0] loc_cnt_reg;
    logic [`DOPFS_IRQ_W-1:0] irq_stat_reg;
    logic [`DOPFS_IRQ_W-1:0] irq_en_reg;
    logic [`DOPFS_IRQ_W-1:0] irq_set;
    logic [NCH-1:0] ch_out;
    logic [NCH-1:0] ch_busy;
    logic [NCH-1:0] ch_done;
    logic [NCH-1:0] start_cmd;
    logic [NCH-1:0] stop_cmd;
    logic [1:0] cfg_mode_reg [NCH];
    logic cfg_cont_reg [NCH];
    logic [15:0] lo_w_reg [NCH];
    logic [15:0] hi_w_reg [NCH];
    logic [15:0] count_reg [NCH];
    logic [15:0] delay_reg [NCH];

    // ----------------------------------------
    // 0.1 ms time base
    // ----------------------------------------
    assign tick = tick_cnt_reg == TW'(TICK_CYC - 1);

    always_ff @(posedge ref_clk_i)
    begin
        if (!reset_n_i)
            tick_cnt_reg <= '0;
        else if (ce_i)
            tick_cnt_reg <= tick ? '0 : tick_cnt_reg + TW'(1);
    end

    // ----------------------------------------
    // software writes
    // ----------------------------------------
    assign start_cmd = (wr_i && hit(addr_i, `DOPFS_A_PCMD)) ?
        wdata_i[NCH-1:0] : '0;
    assign stop_cmd = (wr_i && hit(addr_i, `DOPFS_A_PCMD)) ?
        wdata_i[`DOPFS_STOP_LSB +: NCH] : '0;

    always_ff @(posedge ref_clk_i)
    begin
        if (!reset_n_i)
        begin
            doval_reg <= '0;
            fs_stage_reg <= '0;
            fs_applied_reg <= '0;
            host_en_reg <= 1'b0;
            peer_en_reg <= 1'b0;
            host_idle_reg <= '0;
            peer_idle_reg <= '0;
            irq_en_reg <= '0;
        end
        else if (ce_i && wr_i)
        begin
            if (hit(addr_i, `DOPFS_A_DOVAL))
                doval_reg <= wdata_i[NCH-1:0];
            if (hit(addr_i, `DOPFS_A_FS_STAGE))
                fs_stage_reg <= wdata_i[NCH-1:0];
            if (hit(addr_i, `DOPFS_A_FS_APPLY))
                fs_applied_reg <= fs_stage_reg;
            if (hit(addr_i, `DOPFS_A_WDT_CTRL))
            begin
                host_en_reg <= wdata_i[0];
                peer_en_reg <= wdata_i[1];
            end
            if (hit(addr_i, `DOPFS_A_HOST_IDLE))
                host_idle_reg <= wdata_i[IDLE_W-1:0];
            if (hit(addr_i, `DOPFS_A_PEER_IDLE))
                peer_idle_reg <= wdata_i[IDLE_W-1:0];
            if (hit(addr_i, `DOPFS_A_IRQ_EN))
                irq_en_reg <= wdata_i[`DOPFS_IRQ_W-1:0];
        end
    end

    // ----------------------------------------
    // watchdogs
    // ----------------------------------------
    assign host_ev = host_en_reg && !host_exp_reg && !host_pkt_i &&
        host_cnt_reg > host_idle_reg;
    assign peer_ev = peer_en_reg && !peer_exp_reg && !peer_pkt_i &&
        peer_cnt_reg > peer_idle_reg;
    assign failsafe = host_exp_reg || peer_exp_reg;

    always_ff @(posedge ref_clk_i)
    begin
        if (!reset_n_i)
        begin
            host_cnt_reg <= '0;
            host_exp_reg <= 1'b0;
        end
        else if (ce_i)
        begin
            if (host_pkt_i || !host_en_reg)
            begin
                host_cnt_reg <= '0;
                host_exp_reg <= 1'b0;
            end
            else if (host_ev)
                host_exp_reg <= 1'b1;
            else if (tick && !host_exp_reg)
                host_cnt_reg <= host_cnt_reg + IDLE_W'(1);
        end
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (!reset_n_i)
        begin
            peer_cnt_reg <= '0;
            peer_exp_reg <= 1'b0;
        end
        else if (ce_i)
        begin
            if (peer_pkt_i || !peer_en_reg)
            begin
                peer_cnt_reg <= '0;
                peer_exp_reg <= 1'b0;
            end
            else if (peer_ev)
                peer_exp_reg <= 1'b1;
            else if (tick && !peer_exp_reg)
                peer_cnt_reg <= peer_cnt_reg + IDLE_W'(1);
        end
    end

    // ----------------------------------------
    // channels
    // ----------------------------------------
    genvar g;
    generate
        for (g = 0; g < NCH; g++)
        begin : gen_ch
            localparam logic [7:0] BASE =
                8'(`DOPFS_A_CH_BASE + g * `DOPFS_CH_STRIDE);
            dopfs_mode_t mode;
            logic [15:0] cnt_reg;
            logic [15:0] left_reg;
            logic out_reg;
            logic busy_reg;
            logic done_reg;
            logic hold;
            assign mode = mode_dec(cfg_mode_reg[g]);
            // delayed direction pending
            assign hold = (mode == DOPFS_L2H && doval_reg[g]) ||
                (mode == DOPFS_H2L && !doval_reg[g]);
            assign ch_out[g] = out_reg;
            assign ch_busy[g] = busy_reg;
            assign ch_done[g] = done_reg;

            always_ff @(posedge ref_clk_i)
            begin
                if (!reset_n_i)
                begin
                    cfg_mode_reg[g] <= '0;
                    cfg_cont_reg[g] <= 1'b0;
                    lo_w_reg[g] <= 16'h0001;
                    hi_w_reg[g] <= 16'h0001;
                    count_reg[g] <= '0;
                    delay_reg[g] <= '0;
                end
                else if (ce_i && wr_i)
                begin
                    if (hit(addr_i, BASE | 8'(`DOPFS_CH_CFG)))
                    begin
                        cfg_mode_reg[g] <= wdata_i[1:0];
                        cfg_cont_reg[g] <= wdata_i[`DOPFS_CFG_CONT_BIT];
                    end
                    if (hit(addr_i, BASE | 8'(`DOPFS_CH_WIDTH)))
                    begin
                        lo_w_reg[g] <= wdata_i[15:0];
                        hi_w_reg[g] <= wdata_i[`DOPFS_WIDTH_HI_LSB +: 16];
                    end
                    if (hit(addr_i, BASE | 8'(`DOPFS_CH_COUNT)))
                        count_reg[g] <= wdata_i[15:0];
                    if (hit(addr_i, BASE | 8'(`DOPFS_CH_DELAY)))
                        delay_reg[g] <= wdata_i[15:0];
                end
            end

            always_ff @(posedge ref_clk_i)
            begin
                if (!reset_n_i)
                begin
                    cnt_reg <= '0;
                    left_reg <= '0;
                    out_reg <= 1'b0;
                    busy_reg <= 1'b0;
                    done_reg <= 1'b0;
                end
                else if (ce_i)
                begin
                    done_reg <= 1'b0;
                    unique case (mode)
                        DOPFS_PULSE:
                        begin
                            if (stop_cmd[g])
                            begin
                                busy_reg <= 1'b0;
                                out_reg <= 1'b0;
                            end
                            else if (start_cmd[g] &&
                                (cfg_cont_reg[g] || count_reg[g] != 0))
                            begin
                                busy_reg <= 1'b1;
                                out_reg <= 1'b1;
                                cnt_reg <= hi_w_reg[g];
                                left_reg <= count_reg[g];
                            end
                            else if (busy_reg && tick)
                            begin
                                if (cnt_reg > 16'h0001)
                                    cnt_reg <= cnt_reg - 16'h0001;
                                else if (out_reg)
                                begin
                                    out_reg <= 1'b0;
                                    cnt_reg <= lo_w_reg[g];
                                    if (!cfg_cont_reg[g] &&
                                        left_reg == 16'h0001)
                                    begin
                                        busy_reg <= 1'b0;
                                        done_reg <= 1'b1;
                                    end
                                    left_reg <= left_reg - 16'h0001;
                                end
                                else
                                begin
                                    out_reg <= 1'b1;
                                    cnt_reg <= hi_w_reg[g];
                                end
                            end
                        end
                        DOPFS_L2H, DOPFS_H2L:
                        begin
                            busy_reg <= 1'b0;
                            if (doval_reg[g] == out_reg)
                                cnt_reg <= '0;
                            else if (!hold || cnt_reg >= delay_reg[g])
                            begin
                                out_reg <= doval_reg[g];
                                cnt_reg <= '0;
                            end
                            else if (tick)
                                cnt_reg <= cnt_reg + 16'h0001;
                        end
                        DOPFS_DIRECT:
                        begin
                            busy_reg <= 1'b0;
                            out_reg <= doval_reg[g];
                        end
                    endcase
                end
            end
        end
    endgenerate

    // ----------------------------------------
    // locate, pins, interrupts
    // ----------------------------------------
    always_ff @(posedge ref_clk_i)
    begin
        if (!reset_n_i)
            loc_cnt_reg <= '0;
        else if (ce_i)
        begin
            if (wr_i && hit(addr_i, `DOPFS_A_LOCATE) && wdata_i[0])
                loc_cnt_reg <= LW'(LOCATE_TICKS);
            else if (tick && loc_cnt_reg != '0)
                loc_cnt_reg <= loc_cnt_reg - LW'(1);
        end
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (!reset_n_i)
        begin
            do_o <= '0;
            led_o <= 1'b0;
        end
        else if (ce_i)
        begin
            do_o <= failsafe ? fs_applied_reg : ch_out;
            led_o <= loc_cnt_reg != '0;
        end
    end

    always_comb
    begin
        irq_set = '0;
        irq_set[NCH-1:0] = ch_done;
        irq_set[`DOPFS_IRQ_HOST] = host_ev;
        irq_set[`DOPFS_IRQ_PEER] = peer_ev;
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (!reset_n_i)
        begin
            irq_stat_reg <= '0;
            irq_o <= 1'b0;
        end
        else if (ce_i)
        begin
            if (wr_i && hit(addr_i, `DOPFS_A_IRQ_CLR))
                irq_stat_reg <= (irq_stat_reg &
                    ~wdata_i[`DOPFS_IRQ_W-1:0]) | irq_set;
            else
                irq_stat_reg <= irq_stat_reg | irq_set;
            irq_o <= |(irq_stat_reg & irq_en_reg);
        end
    end

    // ----------------------------------------
    // read port
    // ----------------------------------------
    always_ff @(posedge ref_clk_i)
    begin
        if (!reset_n_i)
            rdata_o <= '0;
        else if (ce_i)
        begin
            rdata_o <= '0;
            if (rd_i)
            begin
                unique case (addr_i)
                    `DOPFS_A_DOVAL: rdata_o[NCH-1:0] <= doval_reg;
                    `DOPFS_A_FS_STAGE: rdata_o[NCH-1:0] <= fs_stage_reg;
                    `DOPFS_A_FS_APPLY: rdata_o[NCH-1:0] <= fs_applied_reg;
                    `DOPFS_A_WDT_CTRL: rdata_o[1:0] <= {peer_en_reg,
                        host_en_reg};
                    `DOPFS_A_HOST_IDLE: rdata_o[IDLE_W-1:0] <= host_idle_reg;
                    `DOPFS_A_PEER_IDLE: rdata_o[IDLE_W-1:0] <= peer_idle_reg;
                    `DOPFS_A_STATUS:
                    begin
                        rdata_o[NCH-1:0] <= do_o;
                        rdata_o[`DOPFS_ST_BUSY_LSB +: NCH] <= ch_busy;
                        rdata_o[`DOPFS_ST_HOST_EXP] <= host_exp_reg;
                        rdata_o[`DOPFS_ST_PEER_EXP] <= peer_exp_reg;
                        rdata_o[`DOPFS_ST_FAILSAFE] <= failsafe;
                        rdata_o[`DOPFS_ST_LED] <= led_o;
                    end
                    `DOPFS_A_IRQ_STAT:
                        rdata_o[`DOPFS_IRQ_W-1:0] <= irq_stat_reg;
                    `DOPFS_A_IRQ_EN: rdata_o[`DOPFS_IRQ_W-1:0] <= irq_en_reg;
                    default:
                    begin
                        for (int c = 0; c < NCH; c++)
                        begin
                            if (addr_i == 8'(`DOPFS_A_CH_BASE +
                                c * `DOPFS_CH_STRIDE))
                                rdata_o[2:0] <= {cfg_cont_reg[c],
                                    cfg_mode_reg[c]};
                            if (addr_i == 8'(`DOPFS_A_CH_BASE +
                                c * `DOPFS_CH_STRIDE + `DOPFS_CH_WIDTH))
                                rdata_o <= {hi_w_reg[c], lo_w_reg[c]};
                            if (addr_i == 8'(`DOPFS_A_CH_BASE +
                                c * `DOPFS_CH_STRIDE + `DOPFS_CH_COUNT))
                                rdata_o[15:0] <= count_reg[c];
                            if (addr_i == 8'(`DOPFS_A_CH_BASE +
                                c * `DOPFS_CH_STRIDE + `DOPFS_CH_DELAY))
                                rdata_o[15:0] <= delay_reg[c];
                        end
                    end
                endcase
            end
        end
    end

endmodule
`default_nettype wire

//--- dopfs_dummy_unused.sv
`default_nettype none
`default_nettype wire

//--- dopfs_top_properties.sv
`default_nettype none
// ----------------------------------------
// port checks
// ----------------------------------------
module dopfs_top_properties
#(
    parameter int NCH = 4,
    parameter int TICK_CYC = 4,
    parameter int LOCATE_TICKS = 8
)
(
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    input wire logic ce_i,
    input wire logic [7:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [31:0] rdata_o,
    input wire logic [NCH-1:0] do_o,
    input wire logic led_o,
    input wire logic irq_o
);
    localparam int LED_MAX = (LOCATE_TICKS + 1) * TICK_CYC + 2;
    logic [31:0] led_cnt_reg;
    logic loc_wr;
    logic rd_hit;
    assign loc_wr = ce_i && wr_i && addr_i == 8'h1c && wdata_i[0];
    assign rd_hit = ce_i && rd_i;
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!reset_n_i);
    always_ff @(posedge ref_clk_i)
    begin
        if (!reset_n_i || !led_o || loc_wr)
        begin
            led_cnt_reg <= 32'h0;
        end
        else if (ce_i)
        begin
            led_cnt_reg <= led_cnt_reg + 32'h1;
        end
    end
    chk_rd_quiet: assert property (
        $past(ce_i) && !$past(rd_hit) |-> rdata_o == 32'h0)
        else $error("read data outside read slot");
    chk_rd_unmapped: assert property (
        rd_hit && addr_i == 8'h30 |=> rdata_o == 32'h0)
        else $error("unmapped read not zero");
    chk_stat_outputs: assert property (
        rd_hit && addr_i == 8'h20 |=> rdata_o[NCH-1:0] == $past(do_o))
        else $error("status outputs mismatch");
    chk_stat_led: assert property (
        rd_hit && addr_i == 8'h20 |=> rdata_o[19] == $past(led_o))
        else $error("status indicator mismatch");
    chk_locate_on: assert property (
        loc_wr |-> ##2 led_o)
        else $error("indicator not lit");
    chk_locate_cause: assert property (
        $rose(led_o) |-> $past(loc_wr, 2))
        else $error("indicator lit without request");
    chk_locate_len: assert property (
        led_cnt_reg <= LED_MAX)
        else $error("indicator held too long");
    chk_irq_mask: assert property (
        ce_i && wr_i && addr_i == 8'h28 && wdata_i == 32'h0 |-> ##2 !irq_o)
        else $error("interrupt not masked");
endmodule
bind dopfs_top dopfs_top_properties #(
    .NCH(NCH),
    .TICK_CYC(TICK_CYC),
    .LOCATE_TICKS(LOCATE_TICKS)
) dopfs_top_properties_i (
    .ref_clk_i, .reset_n_i, .ce_i, .addr_i, .wdata_i, .wr_i, .rd_i,
    .rdata_o, .do_o, .led_o, .irq_o);
`default_nettype wire

//--- dopfs_net_model.sv
`default_nettype none
// ----------------------------------------
// network client stand-in
// ----------------------------------------
module dopfs_net_model
#(
    parameter int GAP = 6
)
(
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic host_on_i,
    input wire logic peer_on_i,
    output logic host_pkt_o,
    output logic peer_pkt_o
);
    logic [7:0] gap_reg;
    always_ff @(posedge clk_i)
    begin
        if (!reset_n_i || gap_reg == 8'(GAP - 1))
        begin
            gap_reg <= 8'h0;
        end
        else
        begin
            gap_reg <= gap_reg + 8'h1;
        end
    end
    // one-cycle arrival pulses while traffic runs
    assign host_pkt_o = host_on_i && gap_reg == 8'h0;
    assign peer_pkt_o = peer_on_i && gap_reg == 8'h3;
endmodule
`default_nettype wire

//--- test_dopfs_top.sv
`default_nettype none
// ----------------------------------------
// bench
// ----------------------------------------
module test_dopfs_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int T = 4;
    typedef struct {
        logic [7:0] wa;
        logic [31:0] d;
        logic [7:0] ra;
        logic [31:0] e;
    } dopfs_row_t;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic ce = 1'b1;
    logic [7:0] addr = 8'h0;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic h_on = 1'b1;
    logic p_on = 1'b1;
    logic [31:0] rdata;
    logic [3:0] dout;
    logic led;
    logic irq;
    logic hpkt;
    logic ppkt;
    logic [4:0] mon;
    int fails = 0;
    int comparisons = 0;
    int cyc = 0;
    int n;
    int runs[$];
    dopfs_row_t rows[8];
    assign mon = {led, dout};
    always #20 clk = ~clk;
    dopfs_top #(.TICK_CYC(T), .LOCATE_TICKS(8)) dopfs_top_i (
        .ref_clk_i(clk), .reset_n_i(reset_n), .ce_i(ce), .addr_i(addr),
        .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
        .host_pkt_i(hpkt), .peer_pkt_i(ppkt), .do_o(dout), .led_o(led),
        .irq_o(irq));
    dopfs_net_model dopfs_net_model_i (.clk_i(clk), .reset_n_i(reset_n),
        .host_on_i(h_on), .peer_on_i(p_on), .host_pkt_o(hpkt),
        .peer_pkt_o(ppkt));
    task automatic close_out();
        if (fails == 0 && comparisons > 0)
        begin
            $display("bench passed");
        end
        else
        begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            fails++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic check_rng(input int got, input int lo, input int hi);
        comparisons++;
        if (got < lo || got > hi)
        begin
            fails++;
            $display("ERROR t=%0t got %h exp %h..%h", $time, got, lo, hi);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic check_reg(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        check(rdata, e);
    endtask
    task automatic cycles_to(input int b, input logic lv, output int k);
        k = 0;
        @(negedge clk);
        while (mon[b] !== lv && k < 2000)
        begin
            @(negedge clk);
            k++;
        end
    endtask
    task automatic sample(input int len_max, output int rises);
        int len;
        logic prev;
        len = 0;
        rises = 0;
        prev = dout[0];
        runs.delete();
        repeat (len_max)
        begin
            @(negedge clk);
            len++;
            if (dout[0] !== prev)
            begin
                runs.push_back(len);
                rises += int'(dout[0]);
                len = 0;
                prev = dout[0];
            end
        end
    endtask
    task automatic delay_case(input logic [31:0] dv, input int b,
        input logic lv, input int lo, input int hi);
        wr_reg(8'h00, dv);
        cycles_to(b, lv, n);
        check_rng(n, lo, hi);
    endtask
    task automatic fs_step(input logic h, input logic p, input logic [3:0] e);
        @(posedge clk);
        h_on <= h;
        p_on <= p;
        repeat (50) @(negedge clk);
        check({28'h0, dout}, {28'h0, e});
    endtask
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            fails++;
            close_out();
        end
    end
    initial
    begin
        rows = '{'{8'h44, 32'hffff_0001, 8'h44, 32'hffff_0001},
            '{8'h48, 32'h0000_ffff, 8'h48, 32'h0000_ffff},
            '{8'h4c, 32'h3, 8'h4c, 32'h3}, '{8'h08, 32'h2, 8'h0c, 32'h0},
            '{8'h14, 32'h3, 8'h14, 32'h3}, '{8'h18, 32'h3, 8'h18, 32'h3},
            '{8'h30, 32'hffff_ffff, 8'h30, 32'h0},
            '{8'h28, 32'h0, 8'h24, 32'h0}};
        repeat (4) @(posedge clk);
        reset_n <= 1'b1;
        foreach (rows[i])
        begin
            wr_reg(rows[i].wa, rows[i].d);
            check_reg(rows[i].ra, rows[i].e);
        end
        @(posedge clk);
        reset_n <= 1'b0;
        repeat (4) @(posedge clk);
        reset_n <= 1'b1;
        @(negedge clk);
        check({28'h0, dout}, 32'h0);
        check_reg(8'h44, 32'h0001_0001);
        check_reg(8'h08, 32'h0);
        // fixed count train, then interrupt raise, mask and clear
        wr_reg(8'h40, 32'h1);
        wr_reg(8'h44, 32'h0002_0003);
        wr_reg(8'h48, 32'h3);
        wr_reg(8'h04, 32'h1);
        sample(200, n);
        check(32'(n), 32'h3);
        check(runs[3], 2 * T);
        check(runs[4], 3 * T);
        check_reg(8'h20, 32'h0);
        check_reg(8'h24, 32'h1);
        check({31'h0, irq}, 32'h0);
        wr_reg(8'h28, 32'h1);
        repeat (3) @(negedge clk);
        check({31'h0, irq}, 32'h1);
        wr_reg(8'h2c, 32'h1);
        repeat (3) @(negedge clk);
        check({31'h0, irq}, 32'h0);
        wr_reg(8'h28, 32'h0);
        // continuous train stopped early
        wr_reg(8'h40, 32'h5);
        wr_reg(8'h04, 32'h1);
        sample(100, n);
        check_rng(n, 4, 6);
        wr_reg(8'h04, 32'h0001_0000);
        repeat (3) @(negedge clk);
        check_reg(8'h20, 32'h0);
        check_reg(8'h24, 32'h0);
        // delayed transitions
        wr_reg(8'h50, 32'h2);
        wr_reg(8'h5c, 32'h3);
        wr_reg(8'h60, 32'h3);
        wr_reg(8'h6c, 32'h3);
        delay_case(32'h2, 1, 1'b1, 2 * T, 4 * T + 2);
        delay_case(32'h0, 1, 1'b0, 0, 3);
        delay_case(32'h4, 2, 1'b1, 0, 3);
        delay_case(32'h0, 2, 1'b0, 2 * T, 4 * T + 2);
        // watchdogs and fail-safe values
        wr_reg(8'h40, 32'h0);
        wr_reg(8'h50, 32'h0);
        wr_reg(8'h60, 32'h0);
        wr_reg(8'h00, 32'h9);
        wr_reg(8'h08, 32'h6);
        wr_reg(8'h14, 32'h3);
        wr_reg(8'h18, 32'h3);
        wr_reg(8'h10, 32'h1);
        fs_step(1'b1, 1'b1, 4'h9);
        fs_step(1'b0, 1'b1, 4'h0);
        wr_reg(8'h0c, 32'h0);
        fs_step(1'b0, 1'b1, 4'h6);
        fs_step(1'b1, 1'b1, 4'h9);
        wr_reg(8'h10, 32'h2);
        fs_step(1'b1, 1'b0, 4'h6);
        check_reg(8'h24, 32'h0003_0000);
        // clock enable low freezes outputs and ignores writes
        @(posedge clk);
        ce <= 1'b0;
        wr_reg(8'h00, 32'h0);
        repeat (3) @(negedge clk);
        check({28'h0, dout}, 32'h6);
        @(posedge clk);
        ce <= 1'b1;
        check_reg(8'h00, 32'h9);
        // locate indicator
        wr_reg(8'h1c, 32'h1);
        cycles_to(4, 1'b1, n);
        check_rng(n, 0, 3);
        cycles_to(4, 1'b0, n);
        check_rng(n, 7 * T, 9 * T + 2);
        close_out();
    end
endmodule
`default_nettype wire
